// File: verilog/receive_chain_config_regs.sv
// Purpose: AXI4-Lite register bank and decoders for the analog receive chain
// Assumes: power mode comes from logic on clk_i; a single AXI4-Lite master
// Notes: register byte address is four times its index; 16-bit data in low lanes
// Contract
// - With pattern sync set, all channel ramps start on one cycle.
// - Filter corner codes map to 10, 15, 20, 30, 35, 50 MHz.
// - Integrator control one turns the amplifier offset loop off.
// - Clamp code decodes differently in low-noise and low/medium power mode.
// - Amplifier gain select gives 24 dB at zero, 30 dB at one.
// - Termination resistor bits act only while their enable is one.
// - Single-rate clock select: zero CMOS, one differential input.
// - Path select zero imaging, one continuous wave; host powers others down.
// - Summer disable bit, one disables, acts only in continuous-wave mode.
// - Clock ratio field gives 16x, 8x, 4x or 1x.
// - Eight 4-bit mixer phases, channels one-four low, five-eight high.
// - Preamp gain 18, 24, 15 dB per channel, only with enable set.
// - Enabled attenuator gives N times 6 dB; code zero gives none.
// - Summer power bit, zero powers down, acts only in imaging test.
// - Route-test bit puts amplifier outputs on continuous-wave outputs.
// - Converter input limit bit one enables the extra clamp.
// - Extra 5 MHz lowpass enable; host pairs it with 10 MHz corner.
// - Deep clip bit overrides the clamp level field.
// - Deep clip only valid at 24 dB amplifier gain.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "receive_chain_params.svh"
module receive_chain_config_regs
   import receive_chain_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Register bus
   input wire axil_req_t axi_req_i,
   output axil_rsp_t axi_rsp_o,
   // Power mode of the chain
   input wire logic [1:0] power_mode_i,
   // Ramp start requests and aligned starts
   input wire logic [7:0] ramp_req_i,
   output logic [7:0] ramp_start_o,
   // Decoded analog settings
   output analog_cfg_t cfg_o
);
   localparam int NREG = 9;
   localparam int NCH = 8;

   // Storage slots
   localparam logic [3:0] S_SYNC = 4'h0;
   localparam logic [3:0] S_FILT = 4'h1;
   localparam logic [3:0] S_TERM = 4'h2;
   localparam logic [3:0] S_CWP = 4'h3;
   localparam logic [3:0] S_PHLO = 4'h4;
   localparam logic [3:0] S_PHHI = 4'h5;
   localparam logic [3:0] S_PRE = 4'h6;
   localparam logic [3:0] S_ATT = 4'h7;
   localparam logic [3:0] S_XTRA = 4'h8;

   typedef logic [15:0] reg_word_t;

   // Writable bits per slot, highest slot first
   localparam reg_word_t [NREG-1:0] MASKS = {
      `MSK_XTRA,
      `MSK_ATT,
      `MSK_PH,
      `MSK_PH,
      `MSK_PH,
      `MSK_CWP,
      `MSK_TERM,
      `MSK_FILT,
      `MSK_SYNC
   };

   // Read-only status word
   typedef struct packed {
      logic [6:0] spare;
      logic preamp_applied;
      logic term_applied;
      logic cw_mode;
      logic summer_on;
      clip_level_t amp_clip;
      logic filter_code_ok;
   } status_t;

   // All state of the bank
   typedef struct packed {
      reg_word_t [NREG-1:0] regs;
      analog_cfg_t cfg;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // Bus side handshake wires
   logic wr_req;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [1:0] wr_resp;
   logic [31:0] rd_addr;
   logic [31:0] rd_data;
   logic [1:0] rd_resp;
   logic [4:0] wr_hit;
   logic [4:0] rd_hit;
   status_t status;

   // Decoded pieces feeding the next configuration
   wire logic [39:0] pre_db;
   logic deep_eff;
   logic low_noise;

   // Byte address to {hit, slot}; addresses above the map miss
   function automatic logic [4:0] slot_of(input logic [31:0] addr);
      logic [5:0] idx;
      idx = addr[7:2];
      slot_of = 5'h00;
      if (addr[31:8] != 24'h000000) begin
         slot_of = 5'h00;
      end else if (idx == `IDX_SYNC) begin
         slot_of = {1'b1, S_SYNC};
      end else if (idx == `IDX_FILT) begin
         slot_of = {1'b1, S_FILT};
      end else if (idx == `IDX_TERM) begin
         slot_of = {1'b1, S_TERM};
      end else if (idx == `IDX_CWP) begin
         slot_of = {1'b1, S_CWP};
      end else if (idx == `IDX_PHLO) begin
         slot_of = {1'b1, S_PHLO};
      end else if (idx == `IDX_PHHI) begin
         slot_of = {1'b1, S_PHHI};
      end else if (idx == `IDX_PRE) begin
         slot_of = {1'b1, S_PRE};
      end else if (idx == `IDX_ATT) begin
         slot_of = {1'b1, S_ATT};
      end else if (idx == `IDX_XTRA) begin
         slot_of = {1'b1, S_XTRA};
      end
   endfunction

   // True for the read-only status word
   function automatic logic is_status(input logic [31:0] addr);
      is_status = (addr[31:8] == 24'h000000) && (addr[7:2] == `IDX_STAT);
   endfunction

   // Byte-lane merge; reserved bits never take a written value
   function automatic reg_word_t merge(input reg_word_t old, input reg_word_t val,
                                       input logic [1:0] strb, input reg_word_t msk);
      reg_word_t m;
      m = {{8{strb[1]}}, {8{strb[0]}}} & msk;
      merge = (old & ~m) | (val & m);
   endfunction

   // Per-channel preamplifier gain in dB, zero while not applied or reserved
   function automatic logic [4:0] preamp_db(input logic [1:0] code, input logic apply);
      preamp_db = 5'h00;
      if (apply) begin
         case (code)
            `PRE_C18: preamp_db = `PRE_18_DB;
            `PRE_C24: preamp_db = `PRE_24_DB;
            `PRE_C15: preamp_db = `PRE_15_DB;
            default: preamp_db = 5'h00;
         endcase
      end
   endfunction

   // Bus slave
   axil_port u_bus (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .req_i(axi_req_i),
      .rsp_o(axi_rsp_o),
      .wr_req_o(wr_req),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data),
      .wr_strb_o(wr_strb),
      .wr_resp_i(wr_resp),
      .rd_addr_o(rd_addr),
      .rd_data_i(rd_data),
      .rd_resp_i(rd_resp)
   );

   // Ramp start alignment across the eight channels
   ramp_align #(
      .CHANNELS(NCH)
   ) u_ramp (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .sync_en_i(st_r.regs[S_SYNC][`B_SYNC]),
      .req_i(ramp_req_i),
      .start_o(ramp_start_o)
   );

   // Per-channel preamplifier decode, gated by the shared enable
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_pre
         assign pre_db[5*ch +: 5] = preamp_db(st_r.regs[S_PRE][2*ch +: 2],
                                              st_r.regs[S_TERM][`B_PRE_EN]);
      end
   endgenerate

   // Address decode for both directions
   assign wr_hit = slot_of(wr_addr);
   assign rd_hit = slot_of(rd_addr);

   // Status word shows the decoded state, plus the raw preamp and termination enable bits
   always_comb begin
      status = '0;
      status.preamp_applied = st_r.regs[S_TERM][`B_PRE_EN];
      status.term_applied = st_r.regs[S_TERM][`B_TERM_EN];
      status.cw_mode = st_r.cfg.path_select;
      status.summer_on = st_r.cfg.summer_on;
      status.amp_clip = st_r.cfg.amp_clip;
      status.filter_code_ok = st_r.cfg.filter_code_ok;
   end

   // Answers: status is read-only, anything unmapped is a decode error
   always_comb begin
      wr_resp = `RESP_OKAY;
      if (!wr_hit[4]) begin
         wr_resp = is_status(wr_addr) ? `RESP_SLVERR : `RESP_DECERR;
      end
      rd_data = 32'h00000000;
      rd_resp = `RESP_OKAY;
      if (rd_hit[4]) begin
         rd_data = {16'h0000, st_r.regs[rd_hit[3:0]]};
      end else if (is_status(rd_addr)) begin
         rd_data = {16'h0000, status};
      end else begin
         rd_resp = `RESP_DECERR;
      end
   end

   // Clamp qualifiers: deep clip only counts at the low gain setting
   assign deep_eff = st_r.regs[S_XTRA][`B_DEEP] && !st_r.regs[S_FILT][`B_AGAIN];
   assign low_noise = (power_mode_i == `PM_LOW_NOISE);

   // Next state: register writes, then decode of the current fields
   always_comb begin
      st_nxt = st_r;
      if (wr_req && wr_hit[4]) begin
         st_nxt.regs[wr_hit[3:0]] = merge(st_r.regs[wr_hit[3:0]], wr_data[15:0],
                                          wr_strb[1:0], MASKS[wr_hit[3:0]]);
      end

      // Filter corner; unlisted codes are flagged, not guessed
      st_nxt.cfg.filter_code_ok = 1'b1;
      case (st_r.regs[S_FILT][`F_FILT])
         `FC_10: st_nxt.cfg.filter_mhz = `MHZ_10;
         `FC_15: st_nxt.cfg.filter_mhz = `MHZ_15;
         `FC_20: st_nxt.cfg.filter_mhz = `MHZ_20;
         `FC_30: st_nxt.cfg.filter_mhz = `MHZ_30;
         `FC_35: st_nxt.cfg.filter_mhz = `MHZ_35;
         `FC_50: st_nxt.cfg.filter_mhz = `MHZ_50;
         default: begin
            st_nxt.cfg.filter_mhz = 6'h00;
            st_nxt.cfg.filter_code_ok = 1'b0;
         end
      endcase
      // Extra lowpass is passed on; pairing with the 10 MHz corner is software's job
      st_nxt.cfg.extra_lowpass_enable = st_r.regs[S_XTRA][`B_XLP];

      // Amplifier offset loop and gain
      st_nxt.cfg.amp_offset_loop_on = !st_r.regs[S_FILT][`B_LOOP];
      st_nxt.cfg.amp_gain_db = st_r.regs[S_FILT][`B_AGAIN] ? `AG_HI_DB : `AG_LO_DB;

      // Clamp: deep clip wins, else the field decoded by power mode
      st_nxt.cfg.amp_clip = CLIP_OFF;
      if (deep_eff) begin
         st_nxt.cfg.amp_clip = CLIP_M6;
      end else if (low_noise) begin
         if (st_r.regs[S_FILT][`F_CLIP] == `CLIP_LN_M2) begin
            st_nxt.cfg.amp_clip = CLIP_M2;
         end else if (st_r.regs[S_FILT][`F_CLIP] == `CLIP_LN_0) begin
            st_nxt.cfg.amp_clip = CLIP_0;
         end
      end else begin
         if (st_r.regs[S_FILT][`F_CLIP] == `CLIP_LP_M2) begin
            st_nxt.cfg.amp_clip = CLIP_M2;
         end else if (st_r.regs[S_FILT][`F_CLIP] == `CLIP_LP_0) begin
            st_nxt.cfg.amp_clip = CLIP_0;
         end
      end

      // Individual termination resistors only under their enable
      st_nxt.cfg.term_resistor_bits = st_r.regs[S_TERM][`B_TERM_EN] ?
                                      st_r.regs[S_TERM][`F_TERM] : 5'h00;

      // Continuous-wave clocking and path
      st_nxt.cfg.single_rate_clock_type = st_r.regs[S_CWP][`B_CLKTYPE];
      st_nxt.cfg.path_select = st_r.regs[S_CWP][`B_PATH];
      case (st_r.regs[S_CWP][`F_RATIO])
         2'h0: st_nxt.cfg.wave_clock_ratio = 5'h10;
         2'h1: st_nxt.cfg.wave_clock_ratio = 5'h08;
         2'h2: st_nxt.cfg.wave_clock_ratio = 5'h04;
         default: st_nxt.cfg.wave_clock_ratio = 5'h01;
      endcase

      // Summing amplifier: each control bit acts only in its own mode
      st_nxt.cfg.summer_on = 1'b0;
      if (st_r.regs[S_CWP][`B_PATH]) begin
         st_nxt.cfg.summer_on = !st_r.regs[S_CWP][`B_SUMDIS];
      end else if (st_r.regs[S_ATT][`B_ROUTE]) begin
         st_nxt.cfg.summer_on = st_r.regs[S_ATT][`B_SUMPWR];
      end

      // Mixer phases, channel one in the lowest nibble
      st_nxt.cfg.chan_mix_phase = {st_r.regs[S_PHHI], st_r.regs[S_PHLO]};
      st_nxt.cfg.chan_preamp_db = pre_db;
      st_nxt.cfg.preamp_highpass_corner = st_r.regs[S_ATT][`F_HPC];

      // Attenuator in whole 6 dB steps
      st_nxt.cfg.atten_db = 6'h00;
      if (st_r.regs[S_ATT][`B_ATT_EN]) begin
         st_nxt.cfg.atten_db = 6'({3'h0, st_r.regs[S_ATT][`F_ATT]} * `ATT_STEP_DB);
      end

      // Test routing and input limiter
      st_nxt.cfg.amp_route_test = st_r.regs[S_ATT][`B_ROUTE];
      st_nxt.cfg.converter_input_limit = st_r.regs[S_XTRA][`B_LIMIT];
      st_nxt.cfg.pattern_sync = st_r.regs[S_SYNC][`B_SYNC];
   end

   assign cfg_o = st_r.cfg;

   // State register; reset clears registers and decoded settings, clamp off, until the first decode
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r.regs <= {NREG{`RST_VAL}};
         st_r.cfg <= '0;
         st_r.cfg.amp_clip <= CLIP_OFF;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // receive_chain_config_regs

// File: verilog/receive_chain_params.svh
// Purpose: register indexes, field positions, codes and reset value of the receive chain bank
// Assumes: included by bare name wherever the bank's constants are needed
// Notes: a register's byte address on the bus is four times its index
`ifndef RECEIVE_CHAIN_PARAMS_SVH
`define RECEIVE_CHAIN_PARAMS_SVH
// Register indexes
`define IDX_SYNC 6'h0a
`define IDX_FILT 6'h33
`define IDX_TERM 6'h34
`define IDX_CWP 6'h36
`define IDX_PHLO 6'h37
`define IDX_PHHI 6'h38
`define IDX_PRE 6'h39
`define IDX_ATT 6'h3b
`define IDX_XTRA 6'h3d
`define IDX_STAT 6'h3e
// Writable bits of each register; all others are reserved
`define MSK_SYNC 16'h0100
`define MSK_FILT 16'h20ff
`define MSK_TERM 16'h803f
`define MSK_CWP 16'h0f40
`define MSK_PH 16'hffff
`define MSK_ATT 16'h03fc
`define MSK_XTRA 16'he000
`define RST_VAL 16'h0000
// Field positions
`define B_SYNC 8
`define F_FILT 3:0
`define B_LOOP 4
`define F_CLIP 7:5
`define B_AGAIN 13
`define F_TERM 4:0
`define B_TERM_EN 5
`define B_PRE_EN 15
`define B_CLKTYPE 6
`define B_PATH 8
`define B_SUMDIS 9
`define F_RATIO 11:10
`define F_HPC 3:2
`define F_ATT 6:4
`define B_ATT_EN 7
`define B_SUMPWR 8
`define B_ROUTE 9
`define B_LIMIT 13
`define B_XLP 14
`define B_DEEP 15
// Field codes and the values they select
`define FC_10 4'h8
`define FC_15 4'h0
`define FC_20 4'h4
`define FC_30 4'h6
`define FC_35 4'h5
`define FC_50 4'h7
`define MHZ_10 6'h0a
`define MHZ_15 6'h0f
`define MHZ_20 6'h14
`define MHZ_30 6'h1e
`define MHZ_35 6'h23
`define MHZ_50 6'h32
`define CLIP_LN_M2 3'h0
`define CLIP_LN_0 3'h2
`define CLIP_LP_M2 3'h4
`define CLIP_LP_0 3'h6
`define PM_LOW_NOISE 2'h0
`define AG_LO_DB 5'h18
`define AG_HI_DB 5'h1e
`define PRE_C18 2'h0
`define PRE_C24 2'h1
`define PRE_C15 2'h2
`define PRE_18_DB 5'h12
`define PRE_24_DB 5'h18
`define PRE_15_DB 5'h0f
`define ATT_STEP_DB 6'h06
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3
`endif

// File: verilog/receive_chain_pkg.sv
// Purpose: types shared by the receive chain register bank
// Assumes: nothing beyond the constants header
// Notes: AXI4-Lite fields keep their published names
package receive_chain_pkg;
   // Master to slave channels
   typedef struct packed {
      logic [31:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [31:0] araddr;
      logic arvalid;
      logic rready;
   } axil_req_t;
   // Slave to master channels
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_t;
   // Write side progress
   typedef enum logic [1:0] {WS_COLLECT = 2'b01, WS_RESP = 2'b10} wr_state_t;
   // Effective clamp of the amplifier output
   typedef enum logic [3:0] {
      CLIP_OFF = 4'b0001,
      CLIP_M2 = 4'b0010,
      CLIP_0 = 4'b0100,
      CLIP_M6 = 4'b1000
   } clip_level_t;
   // Decoded settings handed to the analog chain
   typedef struct packed {
      logic [5:0] filter_mhz;
      logic filter_code_ok;
      logic extra_lowpass_enable;
      logic amp_offset_loop_on;
      logic [4:0] amp_gain_db;
      clip_level_t amp_clip;
      logic [4:0] term_resistor_bits;
      logic single_rate_clock_type;
      logic path_select;
      logic summer_on;
      logic [4:0] wave_clock_ratio;
      logic [31:0] chan_mix_phase;
      logic [39:0] chan_preamp_db;
      logic [1:0] preamp_highpass_corner;
      logic [5:0] atten_db;
      logic amp_route_test;
      logic converter_input_limit;
      logic pattern_sync;
   } analog_cfg_t;
endpackage

// File: verilog/axil_port.sv
// Purpose: AXI4-Lite slave front end of the receive chain register bank
// Assumes: the register side answers combinationally in the cycle a request shows
// Notes: one write and one read under way at a time
`timescale 1ns/1ps
module axil_port
   import receive_chain_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Bus side
   input wire axil_req_t req_i,
   output axil_rsp_t rsp_o,
   // Register side
   output logic wr_req_o,
   output logic [31:0] wr_addr_o,
   output logic [31:0] wr_data_o,
   output logic [3:0] wr_strb_o,
   input wire logic [1:0] wr_resp_i,
   output logic [31:0] rd_addr_o,
   input wire logic [31:0] rd_data_i,
   input wire logic [1:0] rd_resp_i
);
   typedef struct packed {
      wr_state_t ws;
      logic aw_got;
      logic w_got;
      logic [31:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      axil_rsp_t rsp;
   } state_t;
   localparam state_t ST_RST = '{ws: WS_COLLECT, default: '0};
   state_t st_r;
   state_t st_nxt;

   // Write is shown once both halves are held; read decodes the live address
   assign wr_req_o = (st_r.ws == WS_COLLECT) && st_r.aw_got && st_r.w_got;
   assign wr_addr_o = st_r.awaddr;
   assign wr_data_o = st_r.wdata;
   assign wr_strb_o = st_r.wstrb;
   assign rd_addr_o = req_i.araddr;
   assign rsp_o = st_r.rsp;

   // Address and data are taken in either order, response follows both
   always_comb begin
      st_nxt = st_r;
      if (req_i.awvalid && st_r.rsp.awready) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awaddr = req_i.awaddr;
      end
      if (req_i.wvalid && st_r.rsp.wready) begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = req_i.wdata;
         st_nxt.wstrb = req_i.wstrb;
      end
      case (st_r.ws)
         WS_COLLECT: begin
            if (wr_req_o) begin
               st_nxt.ws = WS_RESP;
               st_nxt.aw_got = 1'b0;
               st_nxt.w_got = 1'b0;
               st_nxt.rsp.bvalid = 1'b1;
               st_nxt.rsp.bresp = wr_resp_i;
            end
         end
         WS_RESP: begin
            if (req_i.bready) begin
               st_nxt.ws = WS_COLLECT;
               st_nxt.rsp.bvalid = 1'b0;
            end
         end
         default: st_nxt.ws = WS_COLLECT;
      endcase
      // Readies drop while a half is held, so the master is stalled, not ignored
      st_nxt.rsp.awready = !st_nxt.aw_got && (st_nxt.ws == WS_COLLECT);
      st_nxt.rsp.wready = !st_nxt.w_got && (st_nxt.ws == WS_COLLECT);
      if (req_i.arvalid && st_r.rsp.arready) begin
         st_nxt.rsp.rvalid = 1'b1;
         st_nxt.rsp.rdata = rd_data_i;
         st_nxt.rsp.rresp = rd_resp_i;
      end else if (req_i.rready && st_r.rsp.rvalid) begin
         st_nxt.rsp.rvalid = 1'b0;
      end
      st_nxt.rsp.arready = !st_nxt.rsp.rvalid;
   end

   // State register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // axil_port

// File: verilog/ramp_align.sv
// Purpose: aligns the start of the per-channel ramp test sequences
// Assumes: start requests come from logic on clk_i
// Notes: with alignment on, one request starts every channel
`timescale 1ns/1ps
module ramp_align #(
   parameter int CHANNELS = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Control and requests
   input wire logic sync_en_i,
   input wire logic [CHANNELS-1:0] req_i,
   // Registered starts
   output logic [CHANNELS-1:0] start_o
);
   typedef struct packed {
      logic [CHANNELS-1:0] start;
   } state_t;
   state_t st_r;
   state_t st_nxt;

   assign start_o = st_r.start;

   // With sync enabled, any request fans out to all channels so their outputs stay in step
   always_comb begin
      st_nxt = st_r;
      st_nxt.start = sync_en_i ? {CHANNELS{|req_i}} : req_i;
   end

   // State register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // ramp_align

// File: verif/receive_chain_config_regs_properties.sv
// Purpose: port checks on the receive chain register bank
// Assumes: one clock, asynchronous active-low reset
// Notes: ramp check skips the cycle after a register update, decode lags one cycle
`timescale 1ns/1ps
module receive_chain_config_regs_properties
   import receive_chain_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Watched ports
   input wire axil_req_t axi_req_i,
   input wire axil_rsp_t axi_rsp_o,
   input wire logic [1:0] power_mode_i,
   input wire logic [7:0] ramp_req_i,
   input wire logic [7:0] ramp_start_o,
   input wire analog_cfg_t cfg_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Bus answers and holding
   a_write_answer: assert property (axi_req_i.awvalid && axi_rsp_o.awready &&
      axi_req_i.wvalid && axi_rsp_o.wready |-> ##2 axi_rsp_o.bvalid)
      else $error("write response late");
   a_bresp_holds: assert property (axi_rsp_o.bvalid && !axi_req_i.bready |=>
      axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp)) else $error("write response dropped");
   a_read_answer: assert property (axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid)
      else $error("read data late");
   a_rdata_holds: assert property (axi_rsp_o.rvalid && !axi_req_i.rready |=>
      axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata)) else $error("read data dropped");
   a_upper_zero: assert property (
      axi_rsp_o.rvalid |-> axi_rsp_o.rdata[31:16] == 16'h0) else $error("upper half set");
   // Ramp starts, aligned when the sync bit is on
   a_ramp_aligned: assert property (!axi_rsp_o.bvalid |=> ramp_start_o ==
      ($past(cfg_o.pattern_sync) ? {8{|$past(ramp_req_i)}} : $past(ramp_req_i)))
      else $error("ramp starts wrong");
   // Relations between decoded settings
   a_deep_clip_gain: assert property (
      cfg_o.amp_clip == CLIP_M6 |-> cfg_o.amp_gain_db == 5'h18) else $error("deep clip at 30 dB");
   a_atten_steps: assert property (cfg_o.atten_db inside
      {6'h0, 6'h06, 6'h0c, 6'h12, 6'h18, 6'h1e, 6'h24, 6'h2a}) else $error("bad attenuation");
   a_summer_gate: assert property (
      cfg_o.summer_on && !cfg_o.path_select |-> cfg_o.amp_route_test) else $error("summer on");
   a_filter_known: assert property (
      cfg_o.filter_code_ok == (cfg_o.filter_mhz != 6'h0)) else $error("corner flag wrong");
   // Main scenarios reached
   c_sync_ramp: cover property (cfg_o.pattern_sync && |ramp_req_i);
   c_deep_clip: cover property (cfg_o.amp_clip == CLIP_M6);
   c_decode_err: cover property (axi_rsp_o.bvalid && axi_rsp_o.bresp == 2'h3);
endmodule // receive_chain_config_regs_properties
bind receive_chain_config_regs receive_chain_config_regs_properties u_props (
   .clk_i(clk_i), .rstn_i(rstn_i), .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o),
   .power_mode_i(power_mode_i), .ramp_req_i(ramp_req_i), .ramp_start_o(ramp_start_o),
   .cfg_o(cfg_o));

// File: verif/tb_receive_chain_config_regs.sv
// Purpose: self-checking bench for the receive chain register bank
// Assumes: one AXI4-Lite master driven on rising edges, seed 90
// Notes: a register model predicts every read, response and decoded setting
`timescale 1ns/1ps
`include "receive_chain_params.svh"
module tb_receive_chain_config_regs
   import receive_chain_pkg::*;
();
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   axil_req_t rq = '0;
   axil_rsp_t rsp;
   logic [1:0] pm = 2'h0;
   logic [7:0] rr = 8'h00;
   logic [7:0] rs;
   analog_cfg_t cfg;
   analog_cfg_t e;
   int n_mismatch = 0;
   int n_tests = 0;
   int j, k;
   logic [31:0] d, v;
   logic [1:0] r;
   logic [15:0] m [64];
   logic [5:0] ix [9] = '{`IDX_SYNC, `IDX_FILT, `IDX_TERM, `IDX_CWP, `IDX_PHLO,
      `IDX_PHHI, `IDX_PRE, `IDX_ATT, `IDX_XTRA};
   logic [15:0] mk [9] = '{`MSK_SYNC, `MSK_FILT, `MSK_TERM, `MSK_CWP, `MSK_PH,
      `MSK_PH, `MSK_PH, `MSK_ATT, `MSK_XTRA};
   // Filter corner per code, zero where the code is unlisted
   logic [5:0] fm [16] = '{6'h0f, 0, 0, 0, 6'h14, 6'h23, 6'h1e, 6'h32, 6'h0a, 0, 0, 0, 0, 0, 0, 0};
   // 100 MHz clock
   always #5 clk_i = ~clk_i;
   receive_chain_config_regs u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .axi_req_i(rq),
      .axi_rsp_o(rsp), .power_mode_i(pm), .ramp_req_i(rr), .ramp_start_o(rs), .cfg_o(cfg));
   // Compare and count; four-state so an unknown never matches
   task chk(input string nm, input logic [127:0] x, input logic [127:0] g);
      n_tests++;
      if (x !== g) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, x, g);
      end
   endtask
   task finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // One write (w=1) or read; each channel released at the edge it is taken
   task xfer(input bit w, input logic [5:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk_i);
      rq.awaddr <= {24'h0, a, 2'b00};
      rq.araddr <= {24'h0, a, 2'b00};
      rq.wdata <= wd;
      rq.wstrb <= 4'hf;
      rq.awvalid <= w;
      rq.wvalid <= w;
      rq.bready <= w;
      rq.arvalid <= !w;
      rq.rready <= !w;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_i);
         if (rsp.awready) rq.awvalid <= 1'b0;
         if (rsp.wready) rq.wvalid <= 1'b0;
         if (rsp.arready) rq.arvalid <= 1'b0;
         if (w ? rsp.bvalid : rsp.rvalid) break;
      end
      d = rsp.rdata;
      r = w ? rsp.bresp : rsp.rresp;
      rq.bready <= 1'b0;
      rq.rready <= 1'b0;
      if (n == 40) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   // Decoded settings predicted from the model registers and power mode
   function automatic analog_cfg_t pred();
      analog_cfg_t x;
      logic [15:0] f, t, c, a, s;
      logic [2:0] cl;
      logic [1:0] p;
      x = '0;
      f = m[`IDX_FILT];
      t = m[`IDX_TERM];
      c = m[`IDX_CWP];
      a = m[`IDX_ATT];
      s = m[`IDX_XTRA];
      cl = f[7:5];
      x.filter_mhz = fm[f[3:0]];
      x.filter_code_ok = fm[f[3:0]] != 6'h0;
      x.extra_lowpass_enable = s[14];
      x.amp_offset_loop_on = !f[4];
      x.amp_gain_db = f[13] ? 5'h1e : 5'h18;
      // Low-noise mode uses codes 0xx, other modes 1xx
      x.amp_clip = CLIP_OFF;
      if (cl == {pm != 2'h0, 2'h0}) x.amp_clip = CLIP_M2;
      if (cl == {pm != 2'h0, 2'h2}) x.amp_clip = CLIP_0;
      if (s[15] && !f[13]) x.amp_clip = CLIP_M6;
      x.term_resistor_bits = t[5] ? t[4:0] : 5'h0;
      x.single_rate_clock_type = c[6];
      x.path_select = c[8];
      x.summer_on = c[8] ? !c[9] : a[9] & a[8];
      x.wave_clock_ratio = c[11] ? (c[10] ? 5'h01 : 5'h04) : (c[10] ? 5'h08 : 5'h10);
      x.chan_mix_phase = {m[`IDX_PHHI], m[`IDX_PHLO]};
      for (int i = 0; i < 8; i++) begin
         p = m[`IDX_PRE][2*i +: 2];
         x.chan_preamp_db[5*i +: 5] = (!t[15] || p == 2'h3) ? 5'h0 :
            p == 2'h0 ? 5'h12 : p == 2'h1 ? 5'h18 : 5'h0f;
      end
      x.preamp_highpass_corner = a[3:2];
      x.atten_db = a[7] ? a[6:4] * 6'h06 : 6'h0;
      x.amp_route_test = a[9];
      x.converter_input_limit = s[13];
      x.pattern_sync = m[`IDX_SYNC][8];
      return x;
   endfunction
   // Main sequence
   initial begin
      void'($urandom(90));
      for (k = 0; k < 64; k++) m[k] = 16'h0;
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      for (k = 0; k < 9; k++) begin
         xfer(0, ix[k], 0);
         chk("reset value", 0, d);
      end
      $display("test reset values done");
      // Random contents everywhere, random power mode, then read back and decode
      for (j = 0; j < 120; j++) begin
         for (k = 0; k < 9; k++) begin
            v = $urandom;
            xfer(1, ix[k], v);
            chk("bresp", `RESP_OKAY, r);
            m[ix[k]] = v[15:0] & mk[k];
         end
         for (k = 0; k < 9; k++) begin
            xfer(0, ix[k], 0);
            chk("rdata", {16'h0, m[ix[k]]}, d);
         end
         e = pred();
         chk("cfg", e, cfg);
         xfer(0, `IDX_STAT, 0);
         chk("status", {m[`IDX_TERM][15], m[`IDX_TERM][5], e.path_select, e.summer_on,
            e.amp_clip, e.filter_code_ok}, d);
         @(posedge clk_i);
         rr <= 8'($urandom);
         pm <= 2'($urandom);
         @(posedge clk_i);
         #1 chk("ramp", m[`IDX_SYNC][8] ? {8{|rr}} : rr, rs);
      end
      $display("test random settings done");
      // Read-only status and unmapped places refuse without effect
      xfer(1, `IDX_STAT, 32'hffff);
      chk("status write", `RESP_SLVERR, r);
      xfer(1, 6'h01, 32'hffff);
      chk("unmapped write", `RESP_DECERR, r);
      xfer(0, 6'h01, 0);
      chk("unmapped read", {`RESP_DECERR, 32'h0}, {r, d});
      xfer(0, `IDX_FILT, 0);
      chk("no effect", m[`IDX_FILT], d);
      $display("test refusals done");
      finish_test();
   end
endmodule // tb_receive_chain_config_regs
